// *** hdl/msbpp_defines.svh ***
// Constants shared by both ends of the multiplexed burst memory port.
`ifndef MSBPP_DEFINES_SVH
`define MSBPP_DEFINES_SVH

// Number of address bits, giving 4,194,304 words.
`define MSBPP_ADDR_W 22
// Width of one stored word.
`define MSBPP_WORD_W 32
// Lines that carry address, then data.
`define MSBPP_SHARED_W 22
// Lanes that only ever carry data.
`define MSBPP_UPPER_W 10
// Byte lanes in one word.
`define MSBPP_LANES 4
// Words moved by every burst.
`define MSBPP_BURST_LEN 4'h8
// Last beat index of a burst.
`define MSBPP_BURST_LAST 4'h7
// Cycles of internal busy time after the command edge.
`define MSBPP_LAT_CYCLES 4'h2
// Word returned by an asynchronous configuration read.
`define MSBPP_CFG_READ_VALUE 32'h0000_0000

`endif

// *** hdl/msbpp_device.sv ***
// Device end: burst memory array behind the multiplexed address/data pins.
//
// Overview of operation
// - Array of 4,194,304 words, 32 bits each.
// - Every burst moves eight words, wrapping.
// - Burst addresses step linearly upward.
// - One word per rising clock edge.
// - Start address taken while address valid low.
// - Shared lines carry address, then data.
// - Upper lanes carry data only.
// - Bus ignored unless chip select low.
// - Standby low powers down after two edges; lane drivers cut asynchronously.
// - Read data driven only with output enable low.
// - Write enable low with address valid: write.
// - Configuration access uses strobes asynchronously.
// - Wait low during the two latency cycles, high otherwise.
// - Byte masks suppress lanes during write bursts.
// - Command taken at edge after address valid falls.
`include "msbpp_defines.svh"

module msbpp_device
#(
    parameter int ADDR_W = `MSBPP_ADDR_W
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    msbpp_if.device bus,
    input wire logic cfg_access_mode,
    output logic standby_active,
    output logic busy
);
    import msbpp_pkg::*;

    localparam int WW = `MSBPP_WORD_W;
    localparam int SW = `MSBPP_SHARED_W;
    localparam int NL = `MSBPP_LANES;

    msbpp_dev_state_t state_q;
    msbpp_dev_state_t state_d;
    logic [ADDR_W-1:0] base_q;
    logic [ADDR_W-1:0] base_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [3:0] lat_q;
    logic [3:0] lat_d;
    logic wr_cmd_q;
    logic wr_cmd_d;
    logic [WW-1:0] dout_q;
    logic [WW-1:0] dout_d;
    logic vld_q;
    logic vld_d;
    logic oe_smp_q;
    logic oe_smp_d;
    logic wait_n_q;
    logic wait_n_d;
    logic adv_prev_q;
    logic adv_prev_d;
    logic stby_meta_q;
    logic stby_q;
    logic adv_fall;
    logic wr_en;
    logic cfg_drive;
    logic burst_drive;
    logic [ADDR_W-1:0] beat_idx;
    logic [WW-1:0] din;
    logic [WW-1:0] rd_word;
    logic [WW-1:0] wr_word;
    logic [WW-1:0] out_word;

    // Storage array, one flip-flop word per location.
    logic [WW-1:0] mem [2**ADDR_W];

    // Full data word as seen on the shared lines plus upper lanes.
    assign din = {bus.upper_data_lanes, bus.shared_addr_data_lines};

    // Low three bits count round inside the aligned group of eight.
    assign beat_idx = {base_q[ADDR_W-1:3], base_q[2:0] + cnt_q[2:0]};
    assign rd_word = mem[beat_idx];

    // Per byte lane merge: a set mask keeps the stored byte.
    generate
        for (genvar g = 0; g < NL; g++)
        begin : g_lane
            assign wr_word[8*g +: 8] = bus.byte_write_mask[g] ?
                                       rd_word[8*g +: 8] : din[8*g +: 8];
        end
    endgenerate

    // A command needs address valid low now and high at the previous edge.
    assign adv_fall = !bus.address_valid_n && adv_prev_q && !bus.chip_select_n
                      && stby_q && !cfg_access_mode;

    // Next-state logic of the burst sequencer.
    always_comb
    begin
        state_d = state_q;
        base_d = base_q;
        cnt_d = cnt_q;
        lat_d = lat_q;
        wr_cmd_d = wr_cmd_q;
        dout_d = dout_q;
        vld_d = 1'b0;
        wr_en = 1'b0;
        if (!stby_q)
        begin
            state_d = DEV_IDLE;
        end
        else
        begin
            unique case (state_q)
                DEV_IDLE:
                begin
                    if (adv_fall)
                    begin
                        base_d = bus.shared_addr_data_lines[ADDR_W-1:0];
                        wr_cmd_d = !bus.write_enable_n;
                        cnt_d = 4'h0;
                        lat_d = 4'h0;
                        state_d = DEV_LAT;
                    end
                end
                DEV_LAT:
                begin
                    if (bus.chip_select_n)
                    begin
                        state_d = DEV_IDLE;
                    end
                    else if (lat_q == `MSBPP_LAT_CYCLES - 4'h1)
                    begin
                        if (wr_cmd_q)
                        begin
                            state_d = DEV_WR;
                        end
                        else
                        begin
                            // First read word leaves on the same edge that wait rises.
                            state_d = DEV_RD;
                            dout_d = rd_word;
                            vld_d = 1'b1;
                            cnt_d = 4'h1;
                        end
                    end
                    else
                    begin
                        lat_d = lat_q + 4'h1;
                    end
                end
                DEV_RD:
                begin
                    if (bus.chip_select_n || cnt_q == `MSBPP_BURST_LEN)
                    begin
                        state_d = DEV_IDLE;
                    end
                    else
                    begin
                        dout_d = rd_word;
                        vld_d = 1'b1;
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                DEV_WR:
                begin
                    if (bus.chip_select_n)
                    begin
                        state_d = DEV_IDLE;
                    end
                    else
                    begin
                        wr_en = 1'b1;
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == `MSBPP_BURST_LAST)
                        begin
                            state_d = DEV_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_d = DEV_IDLE;
                end
            endcase
        end
    end

    // Pin sampling and wait flag for the next cycle.
    always_comb
    begin
        adv_prev_d = bus.address_valid_n;
        oe_smp_d = !bus.output_enable_n && !bus.chip_select_n;
        wait_n_d = (state_d != DEV_LAT);
    end

    // Sequencer and pin-sampling registers.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= DEV_IDLE;
            base_q <= '0;
            cnt_q <= 4'h0;
            lat_q <= 4'h0;
            wr_cmd_q <= 1'b0;
            dout_q <= '0;
            vld_q <= 1'b0;
            oe_smp_q <= 1'b0;
            wait_n_q <= 1'b1;
            adv_prev_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
            lat_q <= lat_d;
            wr_cmd_q <= wr_cmd_d;
            dout_q <= dout_d;
            vld_q <= vld_d;
            oe_smp_q <= oe_smp_d;
            wait_n_q <= wait_n_d;
            adv_prev_q <= adv_prev_d;
        end
    end

    // Two-stage synchroniser on the asynchronous standby pin.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stby_meta_q <= 1'b0;
            stby_q <= 1'b0;
        end
        else
        begin
            stby_meta_q <= bus.standby_select;
            stby_q <= stby_meta_q;
        end
    end

    // Array write port, one merged word per write beat.
    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem[beat_idx] <= wr_word;
        end
    end

    // Configuration reads follow the strobes without the clock.
    assign cfg_drive = cfg_access_mode && !bus.chip_select_n
                       && !bus.output_enable_n;
    assign burst_drive = vld_q && oe_smp_q && !cfg_access_mode;
    assign out_word = cfg_access_mode ? `MSBPP_CFG_READ_VALUE : dout_q;

    // The raw standby pin cuts the drivers at once, with no clock involved.
    assign bus.dev_data_oe = bus.standby_select
                             && (cfg_drive || burst_drive);
    assign bus.dev_shared_o = out_word[SW-1:0];
    assign bus.dev_upper_o = out_word[WW-1:SW];
    assign bus.wait_n = wait_n_q;

    // Status seen by the surrounding logic.
    assign standby_active = !stby_q;
    assign busy = (state_q != DEV_IDLE);
endmodule

// *** hdl/msbpp_host.sv ***
// Host end: controller that issues eight-word bursts over the muxed pins.
`include "msbpp_defines.svh"

module msbpp_host
(
    input wire logic sys_clk,
    input wire logic rstn,
    msbpp_if.host bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [`MSBPP_ADDR_W-1:0] req_addr,
    input wire logic [`MSBPP_WORD_W-1:0] wr_data,
    input wire logic [`MSBPP_LANES-1:0] wr_mask,
    output logic wr_take,
    output logic [`MSBPP_WORD_W-1:0] rd_data,
    output logic rd_valid,
    input wire logic standby_req
);
    import msbpp_pkg::*;

    localparam int WW = `MSBPP_WORD_W;
    localparam int SW = `MSBPP_SHARED_W;

    msbpp_host_state_t state_q;
    msbpp_host_state_t state_d;
    logic write_q;
    logic write_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic adv_n_q;
    logic adv_n_d;
    logic ce_n_q;
    logic ce_n_d;
    logic oe_n_q;
    logic oe_n_d;
    logic we_n_q;
    logic we_n_d;
    logic drive_q;
    logic drive_d;
    logic [WW-1:0] dq_q;
    logic [WW-1:0] dq_d;
    logic [`MSBPP_LANES-1:0] mask_q;
    logic [`MSBPP_LANES-1:0] mask_d;
    logic [WW-1:0] rd_data_q;
    logic [WW-1:0] rd_data_d;
    logic rd_valid_q;
    logic rd_valid_d;
    logic stby_q;
    logic beat;

    // A beat completes at each edge where wait is seen high mid-transfer.
    assign beat = (state_q == HOST_XFER) && bus.wait_n;
    assign req_ready = (state_q == HOST_IDLE) && !standby_req && !stby_q;
    // Current write word is consumed at this edge.
    assign wr_take = write_q && ((state_q == HOST_ADDR) ||
                     (beat && cnt_q != `MSBPP_BURST_LAST));

    // Next-state logic of the host controller.
    always_comb
    begin
        state_d = state_q;
        write_d = write_q;
        cnt_d = cnt_q;
        adv_n_d = 1'b1;
        ce_n_d = ce_n_q;
        oe_n_d = oe_n_q;
        we_n_d = 1'b1;
        drive_d = drive_q;
        dq_d = dq_q;
        mask_d = mask_q;
        rd_data_d = rd_data_q;
        rd_valid_d = 1'b0;
        if (wr_take)
        begin
            dq_d = wr_data;
            mask_d = wr_mask;
        end
        unique case (state_q)
            HOST_IDLE:
            begin
                if (req_valid && req_ready)
                begin
                    state_d = HOST_ADDR;
                    write_d = req_write;
                    adv_n_d = 1'b0;
                    ce_n_d = 1'b0;
                    we_n_d = !req_write;
                    drive_d = 1'b1;
                    dq_d = {{(WW-`MSBPP_ADDR_W){1'b0}}, req_addr};
                    mask_d = '0;
                end
            end
            HOST_ADDR:
            begin
                state_d = HOST_XFER;
                cnt_d = 4'h0;
                drive_d = write_q;
                oe_n_d = write_q;
            end
            HOST_XFER:
            begin
                if (beat)
                begin
                    cnt_d = cnt_q + 4'h1;
                    if (!write_q)
                    begin
                        rd_data_d = {bus.upper_data_lanes, bus.shared_addr_data_lines};
                        rd_valid_d = 1'b1;
                    end
                    if (cnt_q == `MSBPP_BURST_LAST)
                    begin
                        state_d = HOST_IDLE;
                        ce_n_d = 1'b1;
                        oe_n_d = 1'b1;
                        drive_d = 1'b0;
                    end
                end
            end
            default:
            begin
                state_d = HOST_IDLE;
            end
        endcase
    end

    // Controller registers; every pin leaves a flip-flop.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= HOST_IDLE;
            write_q <= 1'b0;
            cnt_q <= 4'h0;
            adv_n_q <= 1'b1;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            drive_q <= 1'b0;
            dq_q <= '0;
            mask_q <= '0;
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
            stby_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            write_q <= write_d;
            cnt_q <= cnt_d;
            adv_n_q <= adv_n_d;
            ce_n_q <= ce_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            drive_q <= drive_d;
            dq_q <= dq_d;
            mask_q <= mask_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            stby_q <= standby_req;
        end
    end

    // Pin drive.
    assign bus.address_valid_n = adv_n_q;
    assign bus.chip_select_n = ce_n_q;
    assign bus.output_enable_n = oe_n_q;
    assign bus.write_enable_n = we_n_q;
    assign bus.standby_select = !stby_q;
    assign bus.byte_write_mask = mask_q;
    assign bus.host_data_oe = drive_q;
    assign bus.host_shared_o = dq_q[SW-1:0];
    assign bus.host_upper_o = dq_q[WW-1:SW];
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
endmodule

// *** hdl/msbpp_if.sv ***
// Pin bundle between the host controller and the burst memory device.
`include "msbpp_defines.svh"

interface msbpp_if;
    logic address_valid_n;
    logic chip_select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic standby_select;
    logic [`MSBPP_LANES-1:0] byte_write_mask;
    logic wait_n;
    // Driver halves of the two-way lanes.
    logic [`MSBPP_SHARED_W-1:0] host_shared_o;
    logic [`MSBPP_UPPER_W-1:0] host_upper_o;
    logic host_data_oe;
    logic [`MSBPP_SHARED_W-1:0] dev_shared_o;
    logic [`MSBPP_UPPER_W-1:0] dev_upper_o;
    logic dev_data_oe;
    // Resolved lane levels; an undriven bus reads as zero.
    logic [`MSBPP_SHARED_W-1:0] shared_addr_data_lines;
    logic [`MSBPP_UPPER_W-1:0] upper_data_lanes;

    // Device drive wins; both ends driving at once is a protocol fault.
    assign shared_addr_data_lines = dev_data_oe ? dev_shared_o :
                                    (host_data_oe ? host_shared_o : '0);
    assign upper_data_lanes = dev_data_oe ? dev_upper_o :
                              (host_data_oe ? host_upper_o : '0);

    modport host
    (
        output address_valid_n, chip_select_n, output_enable_n, write_enable_n,
        output standby_select, byte_write_mask, host_shared_o, host_upper_o,
        output host_data_oe,
        input wait_n, shared_addr_data_lines, upper_data_lanes
    );

    modport device
    (
        input address_valid_n, chip_select_n, output_enable_n, write_enable_n,
        input standby_select, byte_write_mask, shared_addr_data_lines,
        input upper_data_lanes,
        output wait_n, dev_shared_o, dev_upper_o, dev_data_oe
    );
endinterface

// *** hdl/msbpp_pkg.sv ***
// Types shared by both ends of the multiplexed burst memory port.
package msbpp_pkg;

    // Device-end burst sequencer states.
    typedef enum logic [3:0]
    {
        DEV_IDLE = 4'b0001,
        DEV_LAT = 4'b0010,
        DEV_RD = 4'b0100,
        DEV_WR = 4'b1000
    } msbpp_dev_state_t;

    // Host-end controller states.
    typedef enum logic [2:0]
    {
        HOST_IDLE = 3'b001,
        HOST_ADDR = 3'b010,
        HOST_XFER = 3'b100
    } msbpp_host_state_t;

endpackage

// *** tb/msbpp_monitor.sv ***
// Protocol checker for the pins between the host end and the memory end.
module msbpp_monitor
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cfg_access_mode,
    input wire logic address_valid_n,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic standby_select,
    input wire logic wait_n,
    input wire logic host_data_oe,
    input wire logic dev_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic adv_q;
    logic adv_d;
    logic [1:0] run_q;
    logic [1:0] run_d;
    logic cmd;

    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // Tracks the last address valid level and how long the part has been awake.
    always_comb
    begin
        adv_d = address_valid_n;
        run_d = standby_select ? {run_q[0], 1'h1} : 2'h0;
    end

    // Registers the helper state; the part counts as asleep after reset.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            adv_q <= 1'h1;
            run_q <= 2'h0;
        end
        else
        begin
            adv_q <= adv_d;
            run_q <= run_d;
        end
    end

    // A command edge: address valid falls while selected, awake and not configuring.
    assign cmd = !address_valid_n && adv_q && !chip_select_n && (run_q == 2'h3)
                 && !cfg_access_mode;

    a_wait_after_cmd: assert property (cmd |=> !wait_n [*2] ##1 wait_n)
        else $error("wait output does not follow the command latency");
    a_wait_only_busy: assert property (!wait_n |-> $past(cmd) || $past(cmd, 2))
        else $error("wait output low without a recent command");
    a_read_burst_len: assert property (cmd && write_enable_n |->
        ##3 dev_data_oe [*8] ##1 !dev_data_oe)
        else $error("read burst does not drive exactly eight words");
    a_write_host_drives: assert property (cmd && !write_enable_n |=>
        (host_data_oe && !dev_data_oe) [*8])
        else $error("write burst lanes not left to the host");
    a_drive_gated: assert property (dev_data_oe |-> standby_select &&
        (cfg_access_mode ? (!output_enable_n && !chip_select_n)
        : (!$past(output_enable_n) && !$past(chip_select_n))))
        else $error("device drives without select and output enable");
    a_cfg_drives: assert property (cfg_access_mode && !chip_select_n
        && !output_enable_n && standby_select |-> dev_data_oe)
        else $error("configuration read not driven at once");
    a_standby_quiet: assert property (!standby_select |-> !dev_data_oe)
        else $error("device drives lanes during power-down");
    a_no_contention: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive the lanes");
    a_addr_with_select: assert property ($fell(address_valid_n) |->
        !chip_select_n && host_data_oe && output_enable_n)
        else $error("address phase without select or address drive");
    a_cs_idle_ready: assert property (chip_select_n && $past(chip_select_n)
        |-> wait_n)
        else $error("wait output low while deselected");

    c_read_cmd: cover property (cmd && write_enable_n);
    c_write_cmd: cover property (cmd && !write_enable_n);
    c_power_down: cover property (!standby_select);
    c_cfg_read: cover property (cfg_access_mode && dev_data_oe);
endmodule

// *** tb/msbpp_testbench.sv ***
// Self-checking bench joining the host end to the memory end.
`include "msbpp_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 6;
    logic sys_clk = 1'h0;
    logic rstn = 1'h0;
    logic req_valid = 1'h0;
    logic req_write = 1'h0;
    logic standby_req = 1'h0;
    logic cfg_access_mode = 1'h0;
    logic [21:0] req_addr = 22'h0;
    logic [31:0] wr_data;
    logic [3:0] wr_mask;
    logic req_ready;
    logic wr_take;
    logic rd_valid;
    logic standby_active;
    logic busy;
    logic [31:0] rd_data;
    logic [31:0] ref_mem [64];
    logic [31:0] wbuf [8];
    logic [3:0] mbuf [8];
    logic [2:0] wk = 3'h0;
    logic adv_prev = 1'h1;
    logic [31:0] seed = 32'h0000a134;
    logic [31:0] exp_q [$];
    logic [21:0] addr_q [$];
    int fails = 0;
    int n_checks = 0;

    always #2 sys_clk = ~sys_clk;

    msbpp_if bus_if ();
    msbpp_device #(.ADDR_W(AW)) msbpp_device_i (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_if),
        .cfg_access_mode(cfg_access_mode), .standby_active(standby_active), .busy(busy));
    msbpp_host msbpp_host_i (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_if),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .wr_data(wr_data), .wr_mask(wr_mask), .wr_take(wr_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .standby_req(standby_req));
    msbpp_monitor msbpp_monitor_i (.sys_clk(sys_clk), .rstn(rstn), .cfg_access_mode(cfg_access_mode),
        .address_valid_n(bus_if.address_valid_n), .chip_select_n(bus_if.chip_select_n),
        .output_enable_n(bus_if.output_enable_n), .write_enable_n(bus_if.write_enable_n),
        .standby_select(bus_if.standby_select), .wait_n(bus_if.wait_n),
        .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe));

    // Write data follows the host's take pulses, one buffered word per pulse.
    assign wr_data = wbuf[wk];
    assign wr_mask = mbuf[wk];
    always @(posedge sys_clk)
    begin
        if (wr_take === 1'h1)
            wk <= wk + 3'h1;
    end

    // Returns the next value of the shift-register random source.
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Compares one value and counts the outcome.
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Waits at falling edges, with a bound, until the host accepts requests.
    task automatic wait_ready();
        int i;
        i = 0;
        while (req_ready !== 1'h1 && i < 300)
        begin
            @(negedge sys_clk);
            i++;
        end
        if (req_ready !== 1'h1)
        begin
            fails++;
            conclude();
        end
    endtask

    // Presents one burst request and holds it over the accepting edge.
    task automatic issue(logic wr, logic [21:0] a);
        wait_ready();
        req_write = wr;
        req_addr = a;
        req_valid = 1'h1;
        addr_q.push_back(a);
        @(negedge sys_clk);
        req_valid = 1'h0;
    endtask

    // Writes eight random words and folds the unmasked bytes into the model.
    task automatic do_write(logic [21:0] a, logic masked);
        logic [31:0] r;
        logic [5:0] j;
        wait_ready();
        for (int i = 0; i < 8; i++)
        begin
            wbuf[i] = xorshift();
            r = xorshift();
            mbuf[i] = masked ? r[3:0] : 4'h0;
            j = {a[5:3], a[2:0] + 3'(i)};
            for (int b = 0; b < 4; b++)
                if (!mbuf[i][b])
                    ref_mem[j][b * 8 +: 8] = wbuf[i][b * 8 +: 8];
        end
        issue(1'h1, a);
    endtask

    // Requests a read burst after noting the eight words it must return.
    task automatic do_read(logic [21:0] a);
        wait_ready();
        for (int i = 0; i < 8; i++)
            exp_q.push_back(ref_mem[{a[5:3], a[2:0] + 3'(i)}]);
        issue(1'h0, a);
    endtask

    // Watches returned words and the address phase on the shared lines.
    always @(posedge sys_clk)
    begin
        if (rstn === 1'h1 && rd_valid === 1'h1)
        begin
            if (exp_q.size() == 0)
                check("unexpected word", 32'h0, 32'h1);
            else
                check("read word", exp_q.pop_front(), rd_data);
        end
        if (bus_if.address_valid_n === 1'h0 && adv_prev === 1'h1 && addr_q.size() > 0)
            check("start address", {10'h0, addr_q.pop_front()},
                {10'h0, bus_if.shared_addr_data_lines});
        adv_prev = bus_if.address_valid_n;
    end

    // Cuts a hung run short.
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        conclude();
    end

    // Main sequence: fill, read every start offset, random traffic, power-down.
    initial
    begin
        logic [31:0] r;
        int i;
        repeat (8) @(negedge sys_clk);
        rstn = 1'h1;
        // The device's standby synchroniser needs two edges before a command is taken.
        repeat (2) @(negedge sys_clk);
        for (i = 0; i < 8; i++)
            do_write(22'(i * 8), 1'h0);
        for (i = 0; i < 8; i++)
            do_read(22'(i * 9));
        for (i = 0; i < 30; i++)
        begin
            r = xorshift();
            if (r[0])
                do_write({16'h0, r[8:3]}, 1'h1);
            else
                do_read({16'h0, r[8:3]});
        end
        wait_ready();
        repeat (12) @(negedge sys_clk);
        standby_req = 1'h1;
        repeat (6) @(negedge sys_clk);
        check("standby pin", 32'h0, {31'h0, bus_if.standby_select});
        check("standby flag", 32'h1, {31'h0, standby_active});
        check("lanes released", 32'h0, {31'h0, bus_if.dev_data_oe});
        standby_req = 1'h0;
        repeat (8) @(negedge sys_clk);
        check("awake flag", 32'h0, {31'h0, standby_active});
        do_write(22'h2d, 1'h1);
        do_read(22'h2d);
        do_read(22'h07);
        // A configuration read returns the fixed word on every beat, with no command latched.
        wait_ready();
        cfg_access_mode = 1'h1;
        for (i = 0; i < 8; i++)
            exp_q.push_back(`MSBPP_CFG_READ_VALUE);
        issue(1'h0, 22'h11);
        wait_ready();
        cfg_access_mode = 1'h0;
        for (i = 0; i < 200 && exp_q.size() != 0; i++)
            @(negedge sys_clk);
        check("words outstanding", 32'h0, 32'(exp_q.size()));
        check("sequencer idle", 32'h0, {31'h0, busy});
        conclude();
    end
endmodule
